// ### hdl/trw_pkg.sv
// package for the target-reached window monitor
// assumes a 100 MHz core clock and an object-indexed register port
package trw_pkg;
    // object indices of the register port
    localparam logic [15:0] IDX_POSITION_WINDOW = 16'h6067;
    localparam logic [15:0] IDX_POSITION_WINDOW_TIME = 16'h6068;
    localparam logic [15:0] IDX_VELOCITY_DEMAND = 16'h606B;
    localparam logic [15:0] IDX_VELOCITY_ACTUAL = 16'h606C;
    localparam logic [15:0] IDX_VELOCITY_WINDOW = 16'h606D;
    localparam logic [15:0] IDX_VELOCITY_WINDOW_TIME = 16'h606E;
    localparam logic [15:0] IDX_FOLLOWING_ERROR_TIMEOUT = 16'h6066;
    // preset values
    localparam logic [31:0] RST_POSITION_WINDOW = 32'h0000000A;
    localparam logic [15:0] RST_POSITION_WINDOW_TIME = 16'h0064;
    localparam logic [15:0] RST_VELOCITY_WINDOW = 16'h001E;
    localparam logic [15:0] RST_VELOCITY_WINDOW_TIME = 16'h0000;
    localparam logic [15:0] RST_FOLLOWING_ERROR_TIMEOUT = 16'h0064;
    // window value that switches position monitoring off
    localparam logic [31:0] POSITION_WINDOW_OFF = 32'hFFFFFFFF;
    // status word bit position of target reached
    localparam int TARGET_REACHED_BIT = 10;
    // operating modes
    localparam logic [7:0] MODE_PROFILE_POSITION = 8'h01;
    localparam logic [7:0] MODE_PROFILE_VELOCITY = 8'h03;
    localparam logic [7:0] MODE_INTERPOLATED_POSITION = 8'h07;
    // millisecond tick timing
    localparam int CLK_FREQ_HZ = 100_000_000;
    localparam int TICK_PERIOD_MS = 1;
    localparam int TICK_CYCLES = CLK_FREQ_HZ / 1000 * TICK_PERIOD_MS;
    localparam int TICK_CNT_W = 17;
endpackage

// ### hdl/win_if.sv
// interface carrying one window check to its persistence timer
// assumes both ends share clk_in
`timescale 1ns/10ps
interface win_if;
    logic in_window;
    logic enable;
    logic [15:0] hold_ms;
    logic ms_tick;
    logic reached;
    modport monitor (input in_window, input enable, input hold_ms, input ms_tick,
        output reached);
    modport source (output in_window, output enable, output hold_ms, output ms_tick,
        input reached);
endinterface

// ### hdl/window_timer.sv
// persistence timer: flags reached after in-window lasts longer than hold
// assumes a one-cycle millisecond tick on the same clock
`timescale 1ns/10ps
module window_timer (
    input wire logic clk_in,        // core clock
    input wire logic reset_n_in,    // async reset, active low
    win_if.monitor win              // window check
);
    logic [16:0] ms_reg;
    logic [16:0] ms_next;
    logic reached_reg;
    logic reached_next;

    // count whole ms in window, restart on leaving
    always_comb begin
        ms_next = ms_reg;
        reached_next = reached_reg;
        // [RULE12] restart on exit
        if (!win.enable || !win.in_window) begin
            ms_next = '0;
            reached_next = 1'b0;
        end else begin
            if (win.ms_tick && !reached_reg) begin
                ms_next = ms_reg + 17'd1;
            end
            // [RULE2] longer than hold
            if (ms_reg > {1'b0, win.hold_ms}) begin
                reached_next = 1'b1;
            end
        end
    end

    // state registers
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ms_reg <= '0;
            reached_reg <= 1'b0;
        end else begin
            ms_reg <= ms_next;
            reached_reg <= reached_next;
        end
    end

    assign win.reached = reached_reg;
endmodule

// ### hdl/target_reached_window_monitor.sv
// target-reached window monitor for position and velocity targets
// assumes all inputs are on clk_in except mode, target, ramp and feedback values
// Overview of operation
// [RULE1] Target reached is set when |position - target| is below the position window.
// [RULE2] Position target reached needs the in-window state to last longer than the hold time.
// [RULE3] A position window of all ones switches position monitoring off.
// [RULE4] Position targets count only in profile and interpolated position modes, timed in ms.
// [RULE5] Target reached is set when |speed - set speed| is below the velocity window.
// [RULE6] Velocity target reached needs the in-window state to last longer than the hold time.
// [RULE7] Velocity targets are met only after staying in window for the velocity window time.
// [RULE8] The velocity window, preset 30, is symmetric about the target speed in velocity mode.
// [RULE9] The ramp generator output is shown as velocity demand and is the speed setpoint.
// [RULE10] Actual speed is reported read-only as a signed 32-bit value.
// [RULE11] The following-error timeout is counted in milliseconds.
// [RULE12] Leaving the window early restarts the timer and clears target reached.
`timescale 1ns/10ps
module target_reached_window_monitor
    import trw_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
) (
    input wire logic clk_in,                  // core clock
    input wire logic reset_n_in,              // async reset, active low
    input wire logic [7:0] mode_in,           // operating mode (async)
    input wire logic signed [31:0] pos_actual_in,  // actual position (async)
    input wire logic signed [31:0] pos_target_in,  // target position (async)
    input wire logic signed [31:0] ramp_velocity_in, // ramp generator output (async)
    input wire logic signed [31:0] vel_actual_in,  // measured speed (async)
    input wire logic obj_wr_in,               // object write strobe
    input wire logic [15:0] obj_index_in,     // object index
    input wire logic [31:0] obj_wdata_in,     // write data
    output logic [31:0] obj_rdata_out,        // read data
    output logic obj_hit_out,                 // index is mapped
    output logic signed [31:0] speed_setpoint_out, // setpoint to speed controller
    output logic target_reached_out           // status word bit 10
);
    logic [7:0] mode_s1_reg;
    logic [7:0] mode_s2_reg;
    logic signed [31:0] pa_s1_reg, pa_s2_reg;
    logic signed [31:0] pt_s1_reg, pt_s2_reg;
    logic signed [31:0] rv_s1_reg, rv_s2_reg;
    logic signed [31:0] va_s1_reg, va_s2_reg;
    logic [31:0] pos_win_reg, pos_win_next;
    logic [15:0] pos_time_reg, pos_time_next;
    logic [15:0] vel_win_reg, vel_win_next;
    logic [15:0] vel_time_reg, vel_time_next;
    logic [15:0] fe_to_reg, fe_to_next;
    logic [TICK_CNT_W-1:0] tick_reg, tick_next;
    logic ms_tick;
    logic [32:0] pos_diff;
    logic [32:0] vel_diff;
    logic [32:0] pos_abs;
    logic [32:0] vel_abs;
    logic pos_mode;
    logic vel_mode;
    logic [15:0] pos_hold;
    logic [15:0] vel_hold;
    logic pos_hit;
    logic vel_hit;
    logic [31:0] rdata_reg, rdata_next;
    logic hit_reg, hit_next;
    logic tr_reg, tr_next;

    win_if pos_w ();
    win_if vel_w ();

    // two-flop synchronisers for external values
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mode_s1_reg <= '0;
            mode_s2_reg <= '0;
            pa_s1_reg <= '0;
            pa_s2_reg <= '0;
            pt_s1_reg <= '0;
            pt_s2_reg <= '0;
            rv_s1_reg <= '0;
            rv_s2_reg <= '0;
            va_s1_reg <= '0;
            va_s2_reg <= '0;
        end else begin
            mode_s1_reg <= mode_in;
            mode_s2_reg <= mode_s1_reg;
            pa_s1_reg <= pos_actual_in;
            pa_s2_reg <= pa_s1_reg;
            pt_s1_reg <= pos_target_in;
            pt_s2_reg <= pt_s1_reg;
            rv_s1_reg <= ramp_velocity_in;
            rv_s2_reg <= rv_s1_reg;
            va_s1_reg <= vel_actual_in;
            va_s2_reg <= va_s1_reg;
        end
    end

    // object writes and ms tick divider
    always_comb begin
        pos_win_next = pos_win_reg;
        pos_time_next = pos_time_reg;
        vel_win_next = vel_win_reg;
        vel_time_next = vel_time_reg;
        fe_to_next = fe_to_reg;
        if (obj_wr_in) begin
            case (obj_index_in)
                IDX_POSITION_WINDOW: pos_win_next = obj_wdata_in;
                IDX_POSITION_WINDOW_TIME: pos_time_next = obj_wdata_in[15:0];
                IDX_VELOCITY_WINDOW: vel_win_next = obj_wdata_in[15:0];
                IDX_VELOCITY_WINDOW_TIME: vel_time_next = obj_wdata_in[15:0];
                IDX_FOLLOWING_ERROR_TIMEOUT: fe_to_next = obj_wdata_in[15:0];
                default: pos_win_next = pos_win_reg;
            endcase
        end
        // [RULE11] millisecond time base
        if (tick_reg == TICK_CNT_W'(TICK_DIV - 1)) begin
            tick_next = '0;
        end else begin
            tick_next = tick_reg + TICK_CNT_W'(1);
        end
    end

    // configuration registers
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pos_win_reg <= RST_POSITION_WINDOW;
            pos_time_reg <= RST_POSITION_WINDOW_TIME;
            vel_win_reg <= RST_VELOCITY_WINDOW;
            vel_time_reg <= RST_VELOCITY_WINDOW_TIME;
            fe_to_reg <= RST_FOLLOWING_ERROR_TIMEOUT;
            tick_reg <= '0;
        end else begin
            pos_win_reg <= pos_win_next;
            pos_time_reg <= pos_time_next;
            vel_win_reg <= vel_win_next;
            vel_time_reg <= vel_time_next;
            fe_to_reg <= fe_to_next;
            tick_reg <= tick_next;
        end
    end

    assign ms_tick = (tick_reg == TICK_CNT_W'(TICK_DIV - 1));

    // deviation and window compare
    always_comb begin
        pos_diff = {pa_s2_reg[31], pa_s2_reg} - {pt_s2_reg[31], pt_s2_reg};
        vel_diff = {va_s2_reg[31], va_s2_reg} - {rv_s2_reg[31], rv_s2_reg};
        pos_abs = pos_diff[32] ? 33'(-pos_diff) : pos_diff;
        // [RULE5] symmetric speed range
        vel_abs = vel_diff[32] ? 33'(-vel_diff) : vel_diff;
        // [RULE1] position deviation check
        pos_hit = pos_abs < {1'b0, pos_win_reg};
        // [RULE8] velocity window compare
        vel_hit = vel_abs < {17'h00000, vel_win_reg};
        // [RULE4] position modes only
        pos_mode = (mode_s2_reg == MODE_PROFILE_POSITION) ||
            (mode_s2_reg == MODE_INTERPOLATED_POSITION);
        vel_mode = (mode_s2_reg == MODE_PROFILE_VELOCITY);
        // [RULE2] larger of timeout and window time
        pos_hold = (fe_to_reg > pos_time_reg) ? fe_to_reg : pos_time_reg;
        // [RULE6] [RULE7] larger of timeout and window time
        vel_hold = (fe_to_reg > vel_time_reg) ? fe_to_reg : vel_time_reg;
    end

    // drive window timers
    assign pos_w.in_window = pos_hit;
    // [RULE3] all-ones window disables
    assign pos_w.enable = pos_mode && (pos_win_reg != POSITION_WINDOW_OFF);
    assign pos_w.hold_ms = pos_hold;
    assign pos_w.ms_tick = ms_tick;
    assign vel_w.in_window = vel_hit;
    assign vel_w.enable = vel_mode;
    assign vel_w.hold_ms = vel_hold;
    assign vel_w.ms_tick = ms_tick;

    window_timer u_pos_timer (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .win(pos_w.monitor)
    );

    window_timer u_vel_timer (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .win(vel_w.monitor)
    );

    // read mux and status bit, registered below
    always_comb begin
        hit_next = 1'b1;
        // status word bit from either timer
        tr_next = pos_w.reached | vel_w.reached;
        case (obj_index_in)
            IDX_POSITION_WINDOW: rdata_next = pos_win_reg;
            IDX_POSITION_WINDOW_TIME: rdata_next = {16'h0000, pos_time_reg};
            // [RULE9] demand readback
            IDX_VELOCITY_DEMAND: rdata_next = rv_s2_reg;
            // [RULE10] actual speed readback
            IDX_VELOCITY_ACTUAL: rdata_next = va_s2_reg;
            IDX_VELOCITY_WINDOW: rdata_next = {16'h0000, vel_win_reg};
            IDX_VELOCITY_WINDOW_TIME: rdata_next = {16'h0000, vel_time_reg};
            IDX_FOLLOWING_ERROR_TIMEOUT: rdata_next = {16'h0000, fe_to_reg};
            default: begin
                rdata_next = 32'h00000000;
                hit_next = 1'b0;
            end
        endcase
    end

    // output registers, read answer lags the index by one cycle
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_reg <= 32'h00000000;
            hit_reg <= 1'b0;
            tr_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            hit_reg <= hit_next;
            tr_reg <= tr_next;
        end
    end

    assign obj_rdata_out = rdata_reg;
    assign obj_hit_out = hit_reg;
    // [RULE9] ramp output as setpoint
    assign speed_setpoint_out = rv_s2_reg;
    assign target_reached_out = tr_reg;
endmodule

// ### bench/trw_props.sv
// checker for the target-reached window monitor
// assumes one clock domain and the top's own port names
`timescale 1ns/10ps
module trw_props
    import trw_pkg::*;
#(
    parameter int TICK_DIV = 10
) (
    input wire logic clk_in, // clock
    input wire logic reset_n_in, // reset
    input wire logic [7:0] mode_in, // mode
    input wire logic signed [31:0] pos_actual_in, // position
    input wire logic signed [31:0] pos_target_in, // target
    input wire logic signed [31:0] ramp_velocity_in, // ramp
    input wire logic signed [31:0] vel_actual_in, // speed
    input wire logic obj_wr_in, // write
    input wire logic [15:0] obj_index_in, // index
    input wire logic [31:0] obj_wdata_in, // data
    input wire logic [31:0] obj_rdata_out, // read data
    input wire logic obj_hit_out, // mapped
    input wire logic signed [31:0] speed_setpoint_out, // setpoint
    input wire logic target_reached_out // status
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    logic [31:0] pwin_reg, pwin_next;
    logic [15:0] vwin_reg, vwin_next;
    logic [7:0] mode_reg;
    logic [3:0] age_reg, age_next;
    logic signed [32:0] pd, vd;
    logic pfar, vfar, pmode;
    // window shadows and cycles since mode change
    always_comb begin
        pwin_next = pwin_reg;
        vwin_next = vwin_reg;
        if (obj_wr_in && obj_index_in == IDX_POSITION_WINDOW) pwin_next = obj_wdata_in;
        if (obj_wr_in && obj_index_in == IDX_VELOCITY_WINDOW) vwin_next = obj_wdata_in[15:0];
        age_next = (age_reg == 4'hF) ? age_reg : age_reg + 4'h1;
        if (mode_in != mode_reg) age_next = 4'h0;
    end
    // helper registers
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pwin_reg <= RST_POSITION_WINDOW;
            vwin_reg <= RST_VELOCITY_WINDOW;
            mode_reg <= 8'h00;
            age_reg <= 4'h0;
        end else begin
            pwin_reg <= pwin_next;
            vwin_reg <= vwin_next;
            mode_reg <= mode_in;
            age_reg <= age_next;
        end
    end
    // deviations against the windows
    assign pd = pos_actual_in - pos_target_in;
    assign vd = vel_actual_in - ramp_velocity_in;
    assign pfar = (pd[32] ? -pd : pd) >= $signed({1'b0, pwin_reg});
    assign vfar = (vd[32] ? -vd : vd) >= $signed({17'h0, vwin_reg});
    assign pmode = mode_in == MODE_PROFILE_POSITION || mode_in == MODE_INTERPOLATED_POSITION;
    property p_setpoint;
        $stable(ramp_velocity_in)[*5] |-> speed_setpoint_out == ramp_velocity_in;
    endproperty
    a_setpoint: assert property (p_setpoint) else $error("setpoint not ramp");
    // registered read answer shows one cycle after the index
    property p_actual;
        $stable(vel_actual_in)[*5] ##0 obj_index_in == IDX_VELOCITY_ACTUAL
            |=> obj_rdata_out == $past(vel_actual_in);
    endproperty
    a_actual: assert property (p_actual) else $error("actual speed read");
    property p_win_wr;
        obj_wr_in && obj_index_in == IDX_POSITION_WINDOW |-> ##2
            ($past(obj_index_in) != IDX_POSITION_WINDOW ||
            obj_rdata_out == $past(obj_wdata_in, 2));
    endproperty
    a_win_wr: assert property (p_win_wr) else $error("window write lost");
    property p_age;
        $rose(target_reached_out) |-> age_reg >= 4'h2;
    endproperty
    a_age: assert property (p_age) else $error("set too soon");
    property p_mode;
        !(pmode || mode_in == MODE_PROFILE_VELOCITY)[*5] |-> !target_reached_out;
    endproperty
    a_mode: assert property (p_mode) else $error("set in other mode");
    property p_pos_far;
        (pmode && pfar)[*5] |-> !target_reached_out;
    endproperty
    a_pos_far: assert property (p_pos_far) else $error("set out of window");
    property p_vel_far;
        (mode_in == MODE_PROFILE_VELOCITY && vfar)[*5] |-> !target_reached_out;
    endproperty
    a_vel_far: assert property (p_vel_far) else $error("speed out of window");
    property p_off;
        (pmode && pwin_reg == POSITION_WINDOW_OFF)[*5] |-> !target_reached_out;
    endproperty
    a_off: assert property (p_off) else $error("set while off");
    c_pos: cover property (pmode && target_reached_out);
    c_vel: cover property (mode_in == MODE_PROFILE_VELOCITY && target_reached_out);
    c_off: cover property (pmode && pwin_reg == POSITION_WINDOW_OFF);
endmodule

bind target_reached_window_monitor trw_props #(.TICK_DIV(TICK_DIV)) i_props (.clk_in,
    .reset_n_in, .mode_in, .pos_actual_in, .pos_target_in, .ramp_velocity_in,
    .vel_actual_in, .obj_wr_in, .obj_index_in, .obj_wdata_in, .obj_rdata_out,
    .obj_hit_out, .speed_setpoint_out, .target_reached_out);

// ### bench/obj_master.sv
// object dictionary master that reads and writes device objects
// assumes the device clock; drives after the falling edge
`timescale 1ns/10ps
module obj_master (
    input wire logic clk_in, // clock
    output logic obj_wr_out, // write strobe
    output logic [15:0] obj_index_out, // index
    output logic [31:0] obj_wdata_out, // write data
    input wire logic [31:0] obj_rdata_in, // read data
    input wire logic obj_hit_in // mapped
);
    // idle values
    initial begin
        obj_wr_out = 1'b0;
        obj_index_out = 16'h0000;
        obj_wdata_out = 32'h0;
    end
    // one write, data scrambled once taken
    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        @(negedge clk_in);
        obj_wr_out = 1'b1;
        obj_index_out = idx;
        obj_wdata_out = d;
        @(negedge clk_in);
        obj_wr_out = 1'b0;
        obj_wdata_out = ~d;
    endtask
    // one read, registered answer taken at the next falling edge
    task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic h);
        @(negedge clk_in);
        obj_index_out = idx;
        @(negedge clk_in);
        d = obj_rdata_in;
        h = obj_hit_in;
    endtask
endmodule

// ### bench/tb.sv
// testbench for the target-reached window monitor
// assumes the checker binds itself to the top
`timescale 1ns/10ps
module tb;
    import trw_pkg::*;
    localparam int TD = 10; // ms tick divider
    logic clk_in, reset_n_in, obj_wr_in, obj_hit_out, target_reached_out, rd_h;
    logic [7:0] mode_in;
    logic signed [31:0] pos_actual_in, pos_target_in, ramp_velocity_in, vel_actual_in;
    logic signed [31:0] speed_setpoint_out;
    logic [15:0] obj_index_in;
    logic [31:0] obj_wdata_in, obj_rdata_out, rd_d;
    int n_fail = 0;
    int n_compared = 0;
    target_reached_window_monitor #(.TICK_DIV(TD)) i_dut (.clk_in(clk_in),
        .reset_n_in(reset_n_in), .mode_in(mode_in), .pos_actual_in(pos_actual_in),
        .pos_target_in(pos_target_in), .ramp_velocity_in(ramp_velocity_in),
        .vel_actual_in(vel_actual_in), .obj_wr_in(obj_wr_in), .obj_index_in(obj_index_in),
        .obj_wdata_in(obj_wdata_in), .obj_rdata_out(obj_rdata_out), .obj_hit_out(obj_hit_out),
        .speed_setpoint_out(speed_setpoint_out), .target_reached_out(target_reached_out));
    obj_master i_master (.clk_in(clk_in), .obj_wr_out(obj_wr_in), .obj_index_out(obj_index_in),
        .obj_wdata_out(obj_wdata_in), .obj_rdata_in(obj_rdata_out), .obj_hit_in(obj_hit_out));
    // compare one value
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // status bit compare and object read compare
    task automatic chk_tr(input string n, input logic e);
        chk(n, {31'h0, e}, {31'h0, target_reached_out});
    endtask
    task automatic rchk(input logic [15:0] idx, input logic [31:0] e);
        i_master.rd(idx, rd_d, rd_h);
        chk("object", e, rd_d);
        chk("hit", 32'h1, {31'h0, rd_h});
    endtask
    task automatic drv(input logic [7:0] m, input int pa, input int rv, input int va);
        @(negedge clk_in);
        mode_in = m;
        pos_actual_in = pa;
        pos_target_in = 100;
        ramp_velocity_in = rv;
        vel_actual_in = va;
    endtask
    task automatic wait_hi(input int n);
        for (int i = 0; i < n && target_reached_out !== 1'b1; i++) @(negedge clk_in);
    endtask
    task automatic t_regs();
        rchk(IDX_POSITION_WINDOW, 32'hA);
        rchk(IDX_POSITION_WINDOW_TIME, 32'h64);
        rchk(IDX_VELOCITY_WINDOW, 32'h1E);
        rchk(IDX_VELOCITY_WINDOW_TIME, 32'h0);
        rchk(IDX_FOLLOWING_ERROR_TIMEOUT, 32'h64);
        i_master.wr(IDX_VELOCITY_DEMAND, 32'h55);
        rchk(IDX_VELOCITY_DEMAND, 32'h0);
        i_master.rd(16'h6069, rd_d, rd_h);
        chk("unmapped", 32'h0, {rd_h, rd_d[30:0]});
        $display("test regs done");
    endtask
    task automatic t_pos();
        i_master.wr(IDX_FOLLOWING_ERROR_TIMEOUT, 32'h2);
        i_master.wr(IDX_POSITION_WINDOW_TIME, 32'h3);
        drv(MODE_PROFILE_POSITION, 91, 0, 500);
        repeat (2 * TD) @(negedge clk_in);
        chk_tr("early", 1'b0);
        wait_hi(4 * TD);
        chk_tr("pos set", 1'b1);
        drv(MODE_INTERPOLATED_POSITION, 90, 0, 500);
        repeat (5) @(negedge clk_in);
        chk_tr("pos edge", 1'b0);
        drv(MODE_INTERPOLATED_POSITION, 91, 0, 500);
        repeat (2 * TD) @(negedge clk_in);
        chk_tr("restart", 1'b0);
        wait_hi(4 * TD);
        chk_tr("interp set", 1'b1);
        i_master.wr(IDX_POSITION_WINDOW, 32'hFFFFFFFF);
        repeat (8 * TD) @(negedge clk_in);
        chk_tr("off", 1'b0);
        $display("test pos done");
    endtask
    task automatic t_vel();
        drv(MODE_PROFILE_VELOCITY, 100, -1000, -970);
        repeat (8 * TD) @(negedge clk_in);
        chk_tr("vel edge", 1'b0);
        drv(MODE_PROFILE_VELOCITY, 100, -1000, -1029);
        repeat (TD) @(negedge clk_in);
        chk_tr("vel early", 1'b0);
        wait_hi(5 * TD);
        chk_tr("vel set", 1'b1);
        chk("setpoint", -32'sd1000, speed_setpoint_out);
        rchk(IDX_VELOCITY_ACTUAL, -32'sd1029);
        i_master.wr(IDX_VELOCITY_WINDOW_TIME, 32'h5);
        drv(MODE_PROFILE_VELOCITY, 100, -1000, -1030);
        drv(MODE_PROFILE_VELOCITY, 100, -1000, -971);
        repeat (4 * TD) @(negedge clk_in);
        chk_tr("vel time", 1'b0);
        $display("test vel done");
    endtask
    task automatic stop_test();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    initial begin
        #50us;
        n_fail++;
        stop_test();
    end
    initial begin
        reset_n_in = 1'b0;
        drv(8'h00, 0, 0, 0);
        repeat (7) @(negedge clk_in);
        reset_n_in = 1'b1;
        t_regs();
        t_pos();
        t_vel();
        stop_test();
    end
endmodule
